// ==== hw/abcd_core.sv ====
// Decode and execute core for literal/register add, AND and branch on carry
//
// What this block does
// [RQ1] Opcode 0000 1111: accumulator plus 8-bit literal into accumulator, one cycle.
// [RQ2] Every add updates negative, overflow, carry, nibble carry and zero flags.
// [RQ3] Opcode 0010 00da: accumulator plus file byte plus carry to destination.
// [RQ4] Destination bit zero writes accumulator; one writes the file byte back.
// [RQ5] Bank bit zero uses the access bank; one uses the bank select register.
// [RQ6] Opcode 0000 1011: accumulator AND literal into accumulator.
// [RQ7] Opcode 0001 01da: accumulator AND file byte to selected destination.
// [RQ8] AND updates only negative and zero; carry, nibble carry, overflow kept.
// [RQ9] Opcode 1110 0010 branches only when carry set; offset -128 to 127.
// [RQ10] Taken branch target is incremented counter plus twice signed offset.
// [RQ11] Branch takes one cycle untaken, two taken, second a no-operation.
// [RQ12] Opcode 0010 01da: accumulator plus file byte to selected destination.
// [RQ13] Data ops decode in Q1, read in Q2, process in Q3, write in Q4.
`timescale 1ns/10ps
module abcd_core
(
  input  wire logic                          ref_clk,    // 20 MHz clock
  input  wire logic                          reset,      // Async reset, active high
  input  wire logic                          psel,       // APB select
  input  wire logic                          penable,    // APB access phase
  input  wire logic                          pwrite,     // APB write
  input  wire logic [abcd_pkg::APB_AW-1:0]   paddr,      // APB byte address
  input  wire logic [31:0]                   pwdata,     // APB write data
  output abcd_pkg::abcd_apb_rsp_t            apb_rsp,    // APB prdata/pready/pslverr
  output logic [abcd_pkg::PC_W-1:0]          prog_addr,  // Program fetch byte address
  input  wire logic [abcd_pkg::INSTR_W-1:0]  prog_data,  // Program word at prog_addr
  output abcd_pkg::abcd_dmem_req_t           dmem_req,   // Data memory address/write
  input  wire logic [abcd_pkg::DATA_W-1:0]   dmem_rdata  // Data byte at dmem_req.addr
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  abcd_pkg::abcd_phase_t              phase;
  logic                               run;
  logic [abcd_pkg::DATA_W-1:0]        acc;
  logic [abcd_pkg::FLAGS_W-1:0]       flags;
  logic [abcd_pkg::BANK_W-1:0]        bank_select_reg;
  logic [abcd_pkg::PC_W-1:0]          pc;
  logic [abcd_pkg::INSTR_W-1:0]       ir;
  logic                               flush;
  logic [abcd_pkg::DATA_W-1:0]        operand;
  logic [abcd_pkg::DATA_W-1:0]        result;
  logic                               take_branch;
  logic [abcd_pkg::DADDR_W-1:0]       dmem_addr;
  logic [abcd_pkg::DATA_W-1:0]        dmem_wdata;
  logic                               dmem_we;
  logic [31:0]                        prdata;
  logic                               pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire        op_add_lit    = ~flush & (ir[15:8] == abcd_pkg::OPC_ADD_LIT);        // RQ1
  wire        op_and_lit    = ~flush & (ir[15:8] == abcd_pkg::OPC_AND_LIT);        // RQ6
  wire        op_br_carry   = ~flush & (ir[15:8] == abcd_pkg::OPC_BR_CARRY);       // RQ9
  wire        op_add_file_c = ~flush & (ir[15:10] == abcd_pkg::OPC_ADD_FILE_C);    // RQ3
  wire        op_add_file   = ~flush & (ir[15:10] == abcd_pkg::OPC_ADD_FILE);      // RQ12
  wire        op_and_file   = ~flush & (ir[15:10] == abcd_pkg::OPC_AND_FILE);      // RQ7
  wire        op_file       = op_add_file_c | op_add_file | op_and_file;
  wire        op_add        = op_add_lit | op_add_file | op_add_file_c;
  wire        op_and        = op_and_lit | op_and_file;
  wire        dest_file     = op_file & ir[abcd_pkg::DEST_BIT];                    // RQ4
  wire        use_bsr       = ir[abcd_pkg::BANKSEL_BIT];

  // Access bank splits the 8-bit address space between the low and top banks
  wire [abcd_pkg::BANK_W-1:0] access_bank = ir[7] ? abcd_pkg::ACCESS_HIGH_BANK
                                                  : abcd_pkg::ACCESS_LOW_BANK;
  wire [abcd_pkg::BANK_W-1:0] eff_bank    = use_bsr ? bank_select_reg : access_bank;   // RQ5
  wire [abcd_pkg::DADDR_W-1:0] file_addr  = {eff_bank, ir[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic
  wire       carry_in  = op_add_file_c & flags[abcd_pkg::FLAG_C];                  // RQ3
  wire [8:0] sum9      = {1'b0, acc} + {1'b0, operand} + {8'h00, carry_in};
  wire [4:0] low_sum   = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
  wire [7:0] and_val   = acc & operand;
  wire [7:0] alu_val   = op_and ? and_val : sum9[7:0];
  // Overflow: like-signed inputs giving an unlike-signed sum
  wire       add_ov    = (acc[7] == operand[7]) & (sum9[7] != acc[7]);

  // Flag image after the process phase
  logic [abcd_pkg::FLAGS_W-1:0] next_flags;
  always_comb
  begin
    next_flags = flags;
    if (op_add)
    begin
      next_flags[abcd_pkg::FLAG_C]  = sum9[8];                                     // RQ2
      next_flags[abcd_pkg::FLAG_DC] = low_sum[4];                                  // RQ2
      next_flags[abcd_pkg::FLAG_OV] = add_ov;                                      // RQ2
      next_flags[abcd_pkg::FLAG_N]  = sum9[7];                                     // RQ2
      next_flags[abcd_pkg::FLAG_Z]  = (sum9[7:0] == 8'h00);                        // RQ2
    end
    else if (op_and)
    begin
      next_flags[abcd_pkg::FLAG_N]  = and_val[7];                                  // RQ8
      next_flags[abcd_pkg::FLAG_Z]  = (and_val == 8'h00);                          // RQ8
    end
  end

  // Branch target: counter already points past this word
  wire [abcd_pkg::PC_W-1:0] br_offset = {{7{ir[7]}}, ir[7:0], 1'b0};              // RQ10
  wire [abcd_pkg::PC_W-1:0] br_target = pc + br_offset;                            // RQ10

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl   = (paddr == abcd_pkg::REG_CTRL);
  wire hit_acc    = (paddr == abcd_pkg::REG_ACC);
  wire hit_flags  = (paddr == abcd_pkg::REG_FLAGS);
  wire hit_bank   = (paddr == abcd_pkg::REG_BANK);
  wire hit_pc     = (paddr == abcd_pkg::REG_PC);
  wire hit_ir     = (paddr == abcd_pkg::REG_IR);
  wire hit_any    = hit_ctrl | hit_acc | hit_flags | hit_bank | hit_pc | hit_ir;
  wire wr_commit  = apb_access & pwrite;
  // Core state is only writable while halted, so software never races the core
  wire wr_halted  = wr_commit & ~run;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
      rd_mux[abcd_pkg::CTRL_RUN] = run;
    else if (hit_acc)
      rd_mux[abcd_pkg::DATA_W-1:0] = acc;
    else if (hit_flags)
      rd_mux[abcd_pkg::FLAGS_W-1:0] = flags;
    else if (hit_bank)
      rd_mux[abcd_pkg::BANK_W-1:0] = bank_select_reg;
    else if (hit_pc)
      rd_mux[abcd_pkg::PC_W-1:0] = pc;
    else if (hit_ir)
      rd_mux[abcd_pkg::IR_FLUSH:0] = {flush, ir};
  end

  // Read data and error are captured in setup, so no wait state is needed
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

  assign apb_rsp.prdata  = prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      run <= 1'b0;
    else if (wr_commit & hit_ctrl)
      run <= pwdata[abcd_pkg::CTRL_RUN];
  end

  // Phase sequencer; freezes in place while halted
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase <= abcd_pkg::PH_Q1;
    else if (run)
    begin
      unique case (phase)
        abcd_pkg::PH_Q1: phase <= abcd_pkg::PH_Q2;
        abcd_pkg::PH_Q2: phase <= abcd_pkg::PH_Q3;
        abcd_pkg::PH_Q3: phase <= abcd_pkg::PH_Q4;
        abcd_pkg::PH_Q4: phase <= abcd_pkg::PH_Q1;
      endcase
    end
  end

  wire q1 = run & (phase == abcd_pkg::PH_Q1);
  wire q2 = run & (phase == abcd_pkg::PH_Q2);
  wire q3 = run & (phase == abcd_pkg::PH_Q3);
  wire q4 = run & (phase == abcd_pkg::PH_Q4);

  ////////////////////////////////////////////////////////////////////////////
  // Q1 decode: present the file address
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      dmem_addr <= {abcd_pkg::DADDR_W{1'b0}};
    else if (q1 & op_file)
      dmem_addr <= file_addr;                                                      // RQ13
  end

  // Q2 read: literal or file byte into the operand latch
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      operand <= 8'h00;
    else if (q2)
      operand <= op_file ? dmem_rdata : ir[7:0];                                   // RQ13
  end

  // Q3 process: result, flags and branch decision
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      result      <= 8'h00;
      take_branch <= 1'b0;
      dmem_wdata  <= 8'h00;
      dmem_we     <= 1'b0;
    end
    else if (q3)
    begin
      result      <= alu_val;                                                      // RQ13
      take_branch <= op_br_carry & flags[abcd_pkg::FLAG_C];                        // RQ9
      dmem_wdata  <= alu_val;
      dmem_we     <= dest_file;                                                    // RQ4
    end
    else if (q4)
      dmem_we     <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      flags <= abcd_pkg::FLAGS_RST;
    else if (q3)
      flags <= next_flags;                                                         // RQ2 RQ8
    else if (wr_halted & hit_flags)
      flags <= pwdata[abcd_pkg::FLAGS_W-1:0];
  end

  // Q4 write: accumulator destination
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      acc <= abcd_pkg::ACC_RST;
    else if (q4 & (op_add_lit | op_and_lit | ((op_add | op_and) & ~dest_file)))
      acc <= result;                                                               // RQ1 RQ6 RQ13
    else if (wr_halted & hit_acc)
      acc <= pwdata[abcd_pkg::DATA_W-1:0];
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      bank_select_reg <= abcd_pkg::BANK_RST;
    else if (wr_halted & hit_bank)
      bank_select_reg <= pwdata[abcd_pkg::BANK_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch. A taken branch discards the word fetched behind it, so the
  // following cycle runs as a no-operation while the new target is fetched.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pc    <= abcd_pkg::PC_RST;
      ir    <= abcd_pkg::NOP_WORD;
      flush <= 1'b1;
    end
    else if (q4 & take_branch)
    begin
      pc    <= br_target;                                                          // RQ10
      ir    <= abcd_pkg::NOP_WORD;
      flush <= 1'b1;                                                               // RQ11
    end
    else if (q4)
    begin
      pc    <= pc + abcd_pkg::PC_STEP;                                             // RQ11
      ir    <= prog_data;
      flush <= 1'b0;
    end
    else if (wr_halted & hit_pc)
    begin
      pc    <= pwdata[abcd_pkg::PC_W-1:0];
      ir    <= abcd_pkg::NOP_WORD;
      flush <= 1'b1;
    end
  end

  assign prog_addr      = pc;
  assign dmem_req.addr  = dmem_addr;
  assign dmem_req.wdata = dmem_wdata;
  assign dmem_req.we    = dmem_we;

endmodule

// ==== hw/abcd_pkg.sv ====
// Package for the add, AND and branch-on-carry decode and execute block
package abcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PC_W    = 16;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned APB_AW  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode fields
  localparam logic [7:0] OPC_ADD_LIT    = 8'h0F;  // 0000 1111
  localparam logic [7:0] OPC_AND_LIT    = 8'h0B;  // 0000 1011
  localparam logic [7:0] OPC_BR_CARRY   = 8'hE2;  // 1110 0010
  localparam logic [5:0] OPC_ADD_FILE_C = 6'h08;  // 0010 00
  localparam logic [5:0] OPC_ADD_FILE   = 6'h09;  // 0010 01
  localparam logic [5:0] OPC_AND_FILE   = 6'h05;  // 0001 01
  localparam int unsigned DEST_BIT      = 9;
  localparam int unsigned BANKSEL_BIT   = 8;
  localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;

  // Access bank: low half maps to bank 0, high half to the top bank
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Status flag positions
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z  = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_N  = 4;
  localparam int unsigned FLAGS_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [APB_AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [APB_AW-1:0] REG_ACC   = 8'h04;
  localparam logic [APB_AW-1:0] REG_FLAGS = 8'h08;
  localparam logic [APB_AW-1:0] REG_BANK  = 8'h0C;
  localparam logic [APB_AW-1:0] REG_PC    = 8'h10;
  localparam logic [APB_AW-1:0] REG_IR    = 8'h14;
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned IR_FLUSH  = 16;

  // Reset values
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
  localparam logic [PC_W-1:0]    PC_RST    = 16'h0000;
  localparam logic [PC_W-1:0]    PC_STEP   = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } abcd_phase_t;

  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
    logic               we;
  } abcd_dmem_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } abcd_apb_rsp_t;

endpackage

// ==== tb/abcd_core_checker.sv ====
// Port checker for the add, AND and branch-on-carry core
`timescale 1ns/10ps
module abcd_core_checker
(
  input wire logic                         ref_clk,    // Core clock
  input wire logic                         reset,      // Async reset
  input wire logic                         psel,       // APB select
  input wire logic                         penable,    // APB access phase
  input wire logic                         pwrite,     // APB write
  input wire logic [abcd_pkg::APB_AW-1:0]  paddr,      // APB address
  input wire logic [31:0]                  pwdata,     // APB write data
  input wire abcd_pkg::abcd_apb_rsp_t      apb_rsp,    // APB response
  input wire logic [abcd_pkg::PC_W-1:0]    prog_addr,  // Fetch address
  input wire logic [abcd_pkg::INSTR_W-1:0] prog_data,  // Fetched word
  input wire abcd_pkg::abcd_dmem_req_t     dmem_req,   // Data memory request
  input wire logic [abcd_pkg::DATA_W-1:0]  dmem_rdata  // Data memory byte
);
  wire logic mapped = paddr <= abcd_pkg::REG_IR && paddr[1:0] == 2'b00;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  // Fetch moves once per four-clock instruction cycle at most
  sequence s_pc_hold;
    $stable(prog_addr) [*3];
  endsequence
  a_pready_access: assert property (psel && penable |-> apb_rsp.pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (s_setup ##0 !mapped |=>
    apb_rsp.pslverr && (pwrite || apb_rsp.prdata == 32'h0))
    else $error("unmapped access not flagged");
  a_ok_mapped: assert property (s_setup ##0 mapped |=> !apb_rsp.pslverr)
    else $error("mapped access flagged");
  a_read_upper: assert property (s_setup ##0 (!pwrite && paddr <= abcd_pkg::REG_BANK)
    |=> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_prdata_hold: assert property ($changed(apb_rsp.prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_we_pulse: assert property (dmem_req.we |=> !dmem_req.we)
    else $error("write strobe longer than one clock");
  a_we_addr_set: assert property ($rose(dmem_req.we) |->
    dmem_req.addr == $past(dmem_req.addr, 2))
    else $error("file address not settled before write");
  a_pc_spacing: assert property ($changed(prog_addr) |=> s_pc_hold)
    else $error("fetch address moved within a cycle");
endmodule

// ==== tb/test_add_and_branch_carry_decode.sv ====
// Self-checking bench for the add, AND and branch-on-carry core
`timescale 1ns/10ps
module test_add_and_branch_carry_decode;
  logic                     ref_clk, reset, psel, penable, pwrite;
  logic [7:0]               paddr, rnd, acc_m, v, a0, k1, k2, f0, dmem_rdata;
  logic [31:0]              pwdata;
  logic [15:0]              prog_data, prog_addr;
  abcd_pkg::abcd_apb_rsp_t  apb_rsp;
  abcd_pkg::abcd_dmem_req_t dmem_req;
  logic [15:0]              pmem [0:63];
  logic [7:0]               dmem [0:4095];
  logic [4:0]               fl_m;
  logic [12:0]              r;
  logic [31:0]              rq [$];
  logic [19:0]              wq [$];
  int                       n_errors, total_checks;

  abcd_core u_abcd_core (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata));
  assign prog_data = pmem[prog_addr[6:1]];
  assign dmem_rdata = dmem[dmem_req.addr];

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction
  // Result is {N, OV, Z, DC, C, sum}
  function automatic logic [12:0] add8(input logic [7:0] a, b, input logic ci);
    logic [8:0] s;
    s = a + b + ci;
    return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00,
      ({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0F, s[8], s[7:0]};
  endfunction
  task automatic chk(input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end while (apb_rsp.pready !== 1'b1 && i < 16);
    if (i == 16)
    begin
      n_errors++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  // Preload state while halted, run ten instruction cycles, read back
  task automatic go(input logic [7:0] a, input logic [4:0] f, input logic [3:0] b);
    apb(1'b1, abcd_pkg::REG_ACC, {24'h0, a});
    apb(1'b1, abcd_pkg::REG_FLAGS, {27'h0, f});
    apb(1'b1, abcd_pkg::REG_BANK, {28'h0, b});
    apb(1'b1, abcd_pkg::REG_PC, 32'h0);
    apb(1'b1, abcd_pkg::REG_CTRL, 32'h1);
    repeat (40) @(posedge ref_clk);
    apb(1'b1, abcd_pkg::REG_CTRL, 32'h0);
    rd(abcd_pkg::REG_ACC, {24'h0, acc_m});
    rd(abcd_pkg::REG_FLAGS, {27'h0, fl_m});
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (psel && penable && !pwrite && apb_rsp.pready)
      chk(rq.pop_front(), apb_rsp.prdata);
    if (dmem_req.we === 1'b1)
      chk({12'h0, wq.size() ? wq.pop_front() : 20'hFFFFF},
        {12'h0, dmem_req.addr, dmem_req.wdata});
    if (dmem_req.we)
      dmem[dmem_req.addr] <= dmem_req.wdata;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 8'h61;
    foreach (dmem[i]) dmem[i] = 8'h00;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(8'h40, 32'h0);
    repeat (4)
    begin
      foreach (pmem[i]) pmem[i] = 16'h0000;
      a0 = nxt();
      k1 = nxt();
      k2 = nxt();
      f0 = nxt();
      pmem[0] = {abcd_pkg::OPC_ADD_LIT, k1};
      pmem[1] = {abcd_pkg::OPC_AND_LIT, k2};
      r = add8(a0, k1, 1'b0);
      acc_m = r[7:0] & k2;
      fl_m = {acc_m[7], r[11], acc_m == 8'h00, r[9:8]};
      go(a0, f0[4:0], 4'h0);
    end
    // File ops through access bank and bank register, both destinations
    foreach (pmem[i]) pmem[i] = 16'h0000;
    dmem[12'h310] = 8'h02;
    dmem[12'hF85] = 8'hC2;
    dmem[12'h320] = 8'hF0;
    pmem[0] = {abcd_pkg::OPC_ADD_FILE_C, 2'b01, 8'h10};
    pmem[1] = {abcd_pkg::OPC_ADD_FILE, 2'b10, 8'h85};
    pmem[2] = {abcd_pkg::OPC_AND_FILE, 2'b11, 8'h20};
    r = add8(8'h17, 8'h02, 1'b1);
    a0 = r[7:0];
    r = add8(a0, 8'hC2, 1'b0);
    wq.push_back({12'hF85, r[7:0]});
    v = a0 & 8'hF0;
    wq.push_back({12'h320, v});
    acc_m = a0;
    fl_m = {v[7], r[11], v == 8'h00, r[9:8]};
    go(8'h17, 5'h01, 4'h3);
    for (int c = 0; c < 2; c++)
    begin
      foreach (pmem[i]) pmem[i] = 16'h0000;
      pmem[0] = {abcd_pkg::OPC_BR_CARRY, 8'h01};
      pmem[1] = {abcd_pkg::OPC_ADD_LIT, 8'h01};
      pmem[2] = {abcd_pkg::OPC_ADD_LIT, 8'h10};
      r = add8(c ? 8'h20 : 8'h21, 8'h10, 1'b0);
      acc_m = r[7:0];
      fl_m = r[12:8];
      go(8'h20, {4'h0, c[0]}, 4'h0);
    end
    chk(32'h0, wq.size());
    print_verdict();
  end
endmodule

bind abcd_core abcd_core_checker u_abcd_core_checker (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .apb_rsp(apb_rsp), .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req),
  .dmem_rdata(dmem_rdata));
